// ---- dsr_pkg.sv ----
// package: register map, field positions and reset values of the diagnostic-ready and pin status block
package dsr_pkg;
  // register indices; a register's bus byte address is four times its index
  localparam logic [11:0] IDX_DIAG_COMPARE_READY = 12'h528;
  localparam logic [11:0] IDX_GPIO_PIN_LEVEL = 12'h52A;
  localparam logic [11:0] IDX_COMPARE_CTRL = 12'h530;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h531;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h532;
  localparam logic [11:0] IDX_PIN_MODE = 12'h533;
  // byte addresses on the apb bus
  localparam logic [13:0] ADDR_DIAG_COMPARE_READY = {IDX_DIAG_COMPARE_READY, 2'h0};
  localparam logic [13:0] ADDR_GPIO_PIN_LEVEL = {IDX_GPIO_PIN_LEVEL, 2'h0};
  localparam logic [13:0] ADDR_COMPARE_CTRL = {IDX_COMPARE_CTRL, 2'h0};
  localparam logic [13:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [13:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
  localparam logic [13:0] ADDR_PIN_MODE = {IDX_PIN_MODE, 2'h0};
  // diag_compare_ready field positions
  localparam int BIT_CELL_VS_BAL = 0;
  localparam int BIT_BAL_SWITCH = 1;
  localparam int BIT_BAL_OPEN_WIRE = 2;
  localparam int BIT_CELL_OPEN_WIRE = 3;
  localparam int BIT_PIN_COMPARE = 4;
  localparam int BIT_FILTER = 5;
  // compare control field: go bit
  localparam int BIT_COMPARE_GO = 0;
  // reset values
  localparam logic [7:0] RST_READY = 8'h00;
  localparam logic [7:0] RST_PIN_LEVEL = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_PIN_MODE = 8'h00;
  localparam logic [7:0] READY_IMPL_MASK = 8'h1F;
endpackage

// ---- dsr_sync2.sv ----
// file: two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
module dsr_sync2 #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1_r <= '0;
      syncOut <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end
endmodule

// ---- dsr_status_regs.sv ----
// file: diagnostic-ready flags and gpio pin level registers behind an apb slave
`timescale 1ns/100ps
// Overview of operation
// - pin level register shows each digital GPIO pin level, 0 low, 1 high.
// - first GPIO pin at bit 0, eighth at bit 7; reset all zeros.
// - balancing-switch ready sets when comparison done on all channels and stopped.
// - writing 1 to comparison go clears balancing-switch ready flag.
// - cell versus balancing-path ready sets on completion, clears on go.
module dsr_status_regs (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // diagnostic engine completion pulses (same clock)
  input wire logic cellVsBalanceDone,
  input wire logic balanceSwitchDone,
  input wire logic balanceOpenWireDone,
  input wire logic cellOpenWireDone,
  input wire logic pinCompareDone,
  // asynchronous gpio pin levels
  input wire logic [7:0] gpioPin,
  // go strobe to the comparison engine
  output logic compareGo,
  output logic irq
);

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // bus qualifiers
  logic wrEn;
  logic rdEn;
  logic goWrite;
  logic knownAddr;
  logic [7:0] readyNxt;
  logic [7:0] pinSync;
  logic [7:0] ready_r;
  logic [7:0] pinLevel_r;
  logic [7:0] pinMode_r;
  logic [7:0] irqStatus_r;
  logic [7:0] irqMask_r;
  logic [7:0] doneVec;
  logic [7:0] readyRise;
  // write enables, one per writable word
  logic wrCtrl;
  logic wrIrqStatus;
  logic wrIrqMask;
  logic wrPinMode;
  logic [7:0] rdWord;

  // true for any of the six mapped words; any other address is answered with an error
  function automatic logic addrHit(input logic [13:0] a);
    case (a)
      dsr_pkg::ADDR_DIAG_COMPARE_READY: addrHit = 1'b1;
      dsr_pkg::ADDR_GPIO_PIN_LEVEL: addrHit = 1'b1;
      dsr_pkg::ADDR_COMPARE_CTRL: addrHit = 1'b1;
      dsr_pkg::ADDR_IRQ_STATUS: addrHit = 1'b1;
      dsr_pkg::ADDR_IRQ_MASK: addrHit = 1'b1;
      dsr_pkg::ADDR_PIN_MODE: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  endfunction

  assign knownAddr = addrHit(paddr);
  // zero wait states: every access phase completes on its first edge
  assign pready = 1'b1;
  assign pslverr = psel && penable && !knownAddr;
  // a write lands only through byte lane 0, where every register lives
  assign wrEn = psel && penable && pwrite && knownAddr && pstrb[0];
  // read data is loaded at the setup edge so that it stands through the access phase
  assign rdEn = psel && !penable && !pwrite;
  assign wrCtrl = wrEn && (paddr == dsr_pkg::ADDR_COMPARE_CTRL);
  assign wrIrqStatus = wrEn && (paddr == dsr_pkg::ADDR_IRQ_STATUS);
  assign wrIrqMask = wrEn && (paddr == dsr_pkg::ADDR_IRQ_MASK);
  assign wrPinMode = wrEn && (paddr == dsr_pkg::ADDR_PIN_MODE);
  assign goWrite = wrCtrl && pwdata[dsr_pkg::BIT_COMPARE_GO];

  // ------------------------------------------------------------
  // go strobe
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      compareGo <= 1'b0;
    end else begin
      // one-cycle pulse to the comparison engine, the cycle after the write
      compareGo <= goWrite;
    end
  end

  // ------------------------------------------------------------
  // diagnostic ready flags
  // ------------------------------------------------------------
  // completion pulses gathered into the flag layout; bits 5 to 7 stay zero
  always_comb begin
    doneVec = 8'h00;
    doneVec[dsr_pkg::BIT_CELL_VS_BAL] = cellVsBalanceDone;
    doneVec[dsr_pkg::BIT_BAL_SWITCH] = balanceSwitchDone;
    doneVec[dsr_pkg::BIT_BAL_OPEN_WIRE] = balanceOpenWireDone;
    doneVec[dsr_pkg::BIT_CELL_OPEN_WIRE] = cellOpenWireDone;
    doneVec[dsr_pkg::BIT_PIN_COMPARE] = pinCompareDone;
  end

  // per flag: go clears it, its engine's completion sets it, and a tie leaves it set
  for (genvar i = 0; i < 8; i++) begin : g_readyBit
    always_comb begin
      if (!dsr_pkg::READY_IMPL_MASK[i]) begin
        readyNxt[i] = 1'b0;
      end else if (doneVec[i]) begin
        readyNxt[i] = 1'b1;
      end else if (goWrite) begin
        readyNxt[i] = 1'b0;
      end else begin
        readyNxt[i] = ready_r[i];
      end
    end
  end

  // the flags are read-only to software; only go and the engines move them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ready_r <= dsr_pkg::RST_READY;
    end else begin
      ready_r <= readyNxt;
    end
  end

  // a flag that turns on raises its interrupt status bit
  assign readyRise = readyNxt & ~ready_r;

  // ------------------------------------------------------------
  // gpio pin levels
  // ------------------------------------------------------------
  // pins are asynchronous: two flops before any logic reads them
  dsr_sync2 #(
    .W(8)
  ) u_pinSync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .asyncIn(gpioPin),
    .syncOut(pinSync)
  );

  // only pins in digital mode report; gpioPin[0] is the first pin
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinLevel_r <= dsr_pkg::RST_PIN_LEVEL;
    end else begin
      pinLevel_r <= pinSync & pinMode_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinMode_r <= dsr_pkg::RST_PIN_MODE;
    end else if (wrPinMode) begin
      // one marks a pin as digital; analogue pins read zero in the level register
      pinMode_r <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  // each status bit: set when its ready flag turns on, cleared by writing one; a tie leaves it set
  for (genvar i = 0; i < 8; i++) begin : g_irqBit
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        irqStatus_r[i] <= dsr_pkg::RST_IRQ_STATUS[i];
      end else if (readyRise[i]) begin
        irqStatus_r[i] <= 1'b1;
      end else if (wrIrqStatus && pwdata[i]) begin
        irqStatus_r[i] <= 1'b0;
      end
    end
  end

  // mask: a one lets the matching status bit drive the interrupt
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irqMask_r <= dsr_pkg::RST_MASK;
    end else if (wrIrqMask) begin
      irqMask_r <= pwdata[7:0];
    end
  end

  // level interrupt, high while any unmasked status bit is set
  assign irq = |(irqStatus_r & irqMask_r);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // read multiplexer: the control word is write-only and reads zero
  always_comb begin
    rdWord = 8'h00;
    case (paddr)
      dsr_pkg::ADDR_DIAG_COMPARE_READY: rdWord = ready_r;
      dsr_pkg::ADDR_GPIO_PIN_LEVEL: rdWord = pinLevel_r;
      dsr_pkg::ADDR_IRQ_STATUS: rdWord = irqStatus_r;
      dsr_pkg::ADDR_IRQ_MASK: rdWord = irqMask_r;
      dsr_pkg::ADDR_PIN_MODE: rdWord = pinMode_r;
      default: rdWord = 8'h00;
    endcase
  end

  // upper lanes always read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      prdata <= {24'h000000, rdWord};
    end
  end
endmodule

// ---- dsr_status_asserts.sv ----
// checker for the diagnostic-ready and pin status block
`timescale 1ns/100ps
module dsr_status_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic cellVsBalanceDone,
  input wire logic balanceSwitchDone,
  input wire logic balanceOpenWireDone,
  input wire logic cellOpenWireDone,
  input wire logic pinCompareDone,
  input wire logic compareGo
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic rdSet = psel && !penable && !pwrite && paddr == dsr_pkg::ADDR_DIAG_COMPARE_READY;
  wire logic goWr = psel && penable && pwrite && pstrb[0] && pwdata[dsr_pkg::BIT_COMPARE_GO] &&
                    paddr == dsr_pkg::ADDR_COMPARE_CTRL;
  wire logic anyDone = cellVsBalanceDone | balanceSwitchDone | balanceOpenWireDone | cellOpenWireDone | pinCompareDone;
  go_pulse_a: assert property (goWr |=> compareGo ##1 !compareGo)
    else $error("go write gave no single pulse");
  go_clear_a: assert property (goWr && !anyDone ##1 (!anyDone) [*2] ##1 rdSet |=> prdata[4:0] == 5'h00)
    else $error("ready flags not cleared by go");
  bal_switch_a: assert property (balanceSwitchDone ##1 !goWr ##1 rdSet |=> prdata[dsr_pkg::BIT_BAL_SWITCH])
    else $error("switch ready not set");
  cell_vs_a: assert property (cellVsBalanceDone ##1 !goWr ##1 rdSet |=> prdata[dsr_pkg::BIT_CELL_VS_BAL])
    else $error("cell path ready not set");
  pin_cmp_a: assert property (pinCompareDone ##1 !goWr ##1 rdSet |=> prdata[dsr_pkg::BIT_PIN_COMPARE])
    else $error("pin compare ready not set");
  cell_ow_a: assert property (cellOpenWireDone ##1 !goWr ##1 rdSet |=> prdata[dsr_pkg::BIT_CELL_OPEN_WIRE])
    else $error("cell open wire ready not set");
  bal_ow_a: assert property (balanceOpenWireDone ##1 !goWr ##1 rdSet |=> prdata[dsr_pkg::BIT_BAL_OPEN_WIRE])
    else $error("balance open wire ready not set");
endmodule
bind dsr_status_regs dsr_status_asserts u_dsr_status_asserts (.*);

// ---- testbench.sv ----
// self-checking bench for the diagnostic-ready and pin status block
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, compareGo, irq, er;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [4:0] dn = 5'h00;
  logic [7:0] gpioPin = 8'h00, m, p;
  int err_count = 0, check_count = 0, seed = 95, rdy = 0;
  always #2 ref_clk = ~ref_clk;
  dsr_status_regs u_dsr_status_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cellVsBalanceDone(dn[0]), .balanceSwitchDone(dn[1]), .balanceOpenWireDone(dn[2]),
    .cellOpenWireDone(dn[3]), .pinCompareDone(dn[4]), .gpioPin(gpioPin), .compareGo(compareGo), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [13:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk("prdata", e, rd);
  endtask
  task automatic final_report;
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rdc(dsr_pkg::ADDR_GPIO_PIN_LEVEL, 32'h0);
    rdc(14'h3FFC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    for (int i = 0; i < 4; i++) begin
      m = $random(seed);
      p = $random(seed);
      xfer(1'h1, dsr_pkg::ADDR_PIN_MODE, {24'h0, m});
      gpioPin <= p;
      repeat (4) @(posedge ref_clk);
      rdc(dsr_pkg::ADDR_GPIO_PIN_LEVEL, {24'h0, m & p});
    end
    xfer(1'h1, dsr_pkg::ADDR_IRQ_MASK, 32'h1F);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      dn[i] <= 1'h1;
      @(posedge ref_clk);
      dn <= 5'h00;
      rdy = rdy | (1 << i);
      rdc(dsr_pkg::ADDR_DIAG_COMPARE_READY, rdy);
      chk("irq", 32'h1, {31'h0, irq});
    end
    xfer(1'h1, dsr_pkg::ADDR_IRQ_STATUS, 32'h1F);
    @(negedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    xfer(1'h1, dsr_pkg::ADDR_DIAG_COMPARE_READY, 32'h0);
    rdc(dsr_pkg::ADDR_DIAG_COMPARE_READY, rdy);
    xfer(1'h1, dsr_pkg::ADDR_COMPARE_CTRL, 32'h1);
    @(negedge ref_clk);
    chk("compareGo", 32'h1, {31'h0, compareGo});
    @(negedge ref_clk);
    chk("compareGo", 32'h0, {31'h0, compareGo});
    rdc(dsr_pkg::ADDR_DIAG_COMPARE_READY, 32'h0);
    xfer(1'h1, dsr_pkg::ADDR_IRQ_MASK, 32'h0);
    @(posedge ref_clk);
    dn[0] <= 1'h1;
    @(posedge ref_clk);
    dn <= 5'h00;
    rdy = 1;
    rdc(dsr_pkg::ADDR_DIAG_COMPARE_READY, rdy);
    chk("irq", 32'h0, {31'h0, irq});
    rdc(dsr_pkg::ADDR_IRQ_STATUS, 32'h1);
    xfer(1'h1, dsr_pkg::ADDR_IRQ_MASK, 32'h1);
    @(negedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    final_report;
  end
endmodule
